/* hdl/asc_top.sv */
// Behaviour
// R1: every transfer opens with a command byte
// R2: command picks read/write and target register
// R3: ready low on new word, high after read
// R4: ready high before data register updates
// R5: data word rereadable outside continuous read
// R6: three-wire use with select tied low
// R7: host idles serial clock high
// R8: msb presented as soon as select asserts; code shows ready until the first read clock fall, then the msb
// R9: 32 ones on input reset everything
// R10: host waits 500 ms after reset; testbench waits 10 core clock cycles after the serial reset
// R11: mode 001 runs one conversion then powers down
// R12: 1 ms start-up then two conversion periods
// R13: single mode ready stays high after read
// R14: continuous conversion at power-up, ready per word
// R15: read during completion loses new word
// R16: byte 01011100 enters continuous read
// R17: continuous read: one read per word
// R18: unread word replaced at next completion
// R19: byte 01011000 with ready low exits
// R20: host keeps input low in continuous read
// R21: filter chosen from update rate
// R22: data in on input, out on output
// R23: data register is select 011, read-only
// R24: select high: ignore clock, float output
// R25: msb first, sample rising, shift falling
module asc_top #(
  parameter int DATA_BITS        = 24,
  parameter int OSC_START_CYCLES = asc_pkg::OSC_START_CYC,
  parameter logic [7:0] ID_VALUE = 8'hA5  // arbitrary identification value
) (
  // clock and reset
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST,
  // serial port
  input  wire logic                 SCLK,
  input  wire logic                 DIN,
  input  wire logic                 CS_N,
  output logic                      DOUT_O,
  output logic                      DOUT_OE_N,
  // converter core
  input  wire logic                 CONV_STROBE,
  input  wire logic [DATA_BITS-1:0] CONV_RESULT,
  output logic                      MOD_RUN,
  output logic [1:0]                FILTER_SEL,
  output logic [3:0]                RATE_SEL,
  // settings
  output logic [15:0]               CONFIG_WORD,
  output logic [7:0]                IO_WORD
);

  localparam int CW = $clog2(DATA_BITS + 1);
  localparam int OW = $clog2(OSC_START_CYCLES + 1);
  localparam logic [CW-1:0] L_BYTE = CW'(asc_pkg::LEN_BYTE);
  localparam logic [CW-1:0] L_WORD = CW'(asc_pkg::LEN_WORD);
  localparam logic [CW-1:0] L_DATA = CW'(DATA_BITS);
  localparam logic [CW-1:0] CMD_LAST = CW'(asc_pkg::LEN_BYTE - 1);

  // ==========================================================================
  // pin sampling and clock edges
  logic sclk_q;
  logic din_q;
  logic cs_nq;
  logic sclk_d;
  logic rise_act;
  logic fall_act;

  asc_sync #(.INIT(1'b1)) u_sync_sclk (.clk(CORE_CLK), .rst(RST), .d(SCLK), .q(sclk_q));
  asc_sync #(.INIT(1'b0)) u_sync_din  (.clk(CORE_CLK), .rst(RST), .d(DIN),  .q(din_q));
  asc_sync #(.INIT(1'b1)) u_sync_cs   (.clk(CORE_CLK), .rst(RST), .d(CS_N), .q(cs_nq));

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sclk_d <= 1'b1;
    end else begin
      sclk_d <= sclk_q;
    end
  end

  assign rise_act = sclk_q & ~sclk_d & ~cs_nq;  // [R24] [R25]
  assign fall_act = ~sclk_q & sclk_d & ~cs_nq;  // [R24] [R25]

  // ==========================================================================
  // state declarations
  asc_pkg::asc_state_t  state;
  logic [CW-1:0]        bit_cnt;
  logic [CW-1:0]        len;
  logic [2:0]           sel;
  logic [DATA_BITS-1:0] in_sh;
  logic [DATA_BITS-1:0] out_sh;
  logic                 out_live;
  logic                 cread;
  logic [7:0]           mon_sh;
  logic [2:0]           mon_cnt;
  logic [15:0]          mode;
  logic [15:0]          config_reg;
  logic [7:0]           io_reg;
  logic [OW-1:0]        osc_cnt;
  logic                 sgl_cnt;
  logic                 upd_pend;
  logic [DATA_BITS-1:0] res_hold;
  logic [DATA_BITS-1:0] data_reg;
  logic                 ready_n;
  logic [5:0]           ones_cnt;
  logic                 soft_rst;
  logic [7:0]           cmd_byte;
  logic [2:0]           cmd_rs;
  logic [DATA_BITS-1:0] rd_value;
  logic [CW-1:0]        rd_len;
  logic                 last_bit;
  logic                 wr_fire;
  logic                 rd_fire;
  logic [DATA_BITS-1:0] wr_word;
  logic [2:0]           op;
  logic                 sgl_start;
  logic                 sgl_done;
  logic                 reading;
  logic                 accept;
  logic [1:0]           next_filter;

  // ==========================================================================
  // serial reset by a run of ones
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ones_cnt <= '0;
    end else if (rise_act) begin
      ones_cnt <= (din_q && ones_cnt != asc_pkg::ONES_LAST) ? ones_cnt + 6'h01 : 6'h00;
    end
  end

  assign soft_rst = rise_act & din_q & (ones_cnt == asc_pkg::ONES_LAST);  // [R9]

  // ==========================================================================
  // command decode and register read view
  assign cmd_byte = {in_sh[6:0], din_q};
  assign cmd_rs   = cmd_byte[asc_pkg::CMD_RS_HI:asc_pkg::CMD_RS_LO];
  assign op       = mode[asc_pkg::MODE_OP_HI:asc_pkg::MODE_OP_LO];

  always_comb begin
    rd_value = '0;
    rd_len   = L_BYTE;
    case (cmd_rs)
      asc_pkg::RS_STATUS: begin
        rd_value[DATA_BITS-1-(7-asc_pkg::STATUS_RDY_BIT)] = ready_n;
      end
      asc_pkg::RS_MODE: begin
        rd_value[DATA_BITS-1 -: 16] = mode;
        rd_len = L_WORD;
      end
      asc_pkg::RS_CONFIG: begin
        rd_value[DATA_BITS-1 -: 16] = config_reg;
        rd_len = L_WORD;
      end
      asc_pkg::RS_DATA: begin
        rd_value = data_reg;  // [R23]
        rd_len   = L_DATA;
      end
      asc_pkg::RS_ID: begin
        rd_value[DATA_BITS-1 -: 8] = ID_VALUE;
      end
      asc_pkg::RS_IO: begin
        rd_value[DATA_BITS-1 -: 8] = io_reg;
      end
      default: begin
        rd_len = L_DATA;
      end
    endcase
  end

  assign last_bit = rise_act & (bit_cnt == len - CW'(1));
  assign wr_fire  = last_bit & (state == asc_pkg::ST_WRITE);
  assign rd_fire  = last_bit & (state == asc_pkg::ST_READ) & (sel == asc_pkg::RS_DATA);
  assign wr_word  = {in_sh[DATA_BITS-2:0], din_q};

  // ==========================================================================
  // serial engine
  always_ff @(posedge CORE_CLK) begin
    if (RST || soft_rst) begin
      state   <= asc_pkg::ST_CMD;  // [R1] [R9]
      bit_cnt <= '0;
      len     <= L_BYTE;
      sel     <= asc_pkg::RS_STATUS;
      in_sh   <= '0;
      out_sh  <= '0;
      out_live <= 1'b0;
      cread   <= 1'b0;
      mon_sh  <= '0;
      mon_cnt <= '0;
    end else begin
      if (rise_act) begin
        mon_sh  <= {mon_sh[6:0], din_q};
        mon_cnt <= mon_cnt + 3'h1;
      end
      if (cread && upd_pend) begin
        out_sh  <= res_hold;  // [R17] [R18]
        out_live <= 1'b0;  // [R3]
        len     <= L_DATA;
        sel     <= asc_pkg::RS_DATA;
        state   <= asc_pkg::ST_READ;
        bit_cnt <= '0;
        mon_cnt <= '0;
      end else if (fall_act && state == asc_pkg::ST_READ) begin
        // the first fall of a read only presents the msb, later falls shift
        out_live <= 1'b1;  // [R25]
        if (out_live) begin
          out_sh <= {out_sh[DATA_BITS-2:0], 1'b0};  // [R22] [R25]
        end
      end else if (rise_act) begin
        case (state)
          asc_pkg::ST_CMD: begin
            if (!cread) begin
              in_sh <= wr_word;
              if (bit_cnt == CMD_LAST) begin
                bit_cnt <= '0;
                sel     <= cmd_rs;  // [R2]
                if (cmd_byte[asc_pkg::CMD_WEN_BIT]) begin
                  sel <= sel;
                end else if (!cmd_byte[asc_pkg::CMD_RW_BIT]) begin
                  len   <= rd_len;
                  state <= asc_pkg::ST_WRITE;  // [R2]
                end else if (cmd_rs == asc_pkg::RS_DATA && cmd_byte[asc_pkg::CMD_CREAD_BIT]) begin
                  cread   <= 1'b1;  // [R16]
                  mon_cnt <= '0;
                end else begin
                  out_sh <= rd_value;  // [R5] [R8]
                  out_live <= 1'b0;
                  len    <= rd_len;
                  state  <= asc_pkg::ST_READ;
                end
              end else begin
                bit_cnt <= bit_cnt + CW'(1);
              end
            end
          end
          asc_pkg::ST_WRITE: begin
            in_sh   <= wr_word;  // [R22]
            bit_cnt <= last_bit ? '0 : bit_cnt + CW'(1);
            if (last_bit) begin
              state <= asc_pkg::ST_CMD;  // [R1]
            end
          end
          asc_pkg::ST_READ: begin
            bit_cnt <= last_bit ? '0 : bit_cnt + CW'(1);
            if (last_bit) begin
              state <= asc_pkg::ST_CMD;
            end
          end
          default: begin
            state <= asc_pkg::ST_CMD;
          end
        endcase
      end
      if (cread && rise_act && mon_cnt == 3'h7 && {mon_sh[6:0], din_q} == asc_pkg::CREAD_EXIT
          && !ready_n) begin
        cread   <= 1'b0;  // [R19]
        state   <= asc_pkg::ST_CMD;
        bit_cnt <= '0;
      end
    end
  end

  // ==========================================================================
  // writable registers
  always_ff @(posedge CORE_CLK) begin
    if (RST || soft_rst) begin
      mode       <= asc_pkg::MODE_RESET;  // [R9] [R14]
      config_reg <= asc_pkg::CONFIG_RESET;
      io_reg     <= asc_pkg::IO_RESET;
    end else begin
      if (wr_fire) begin
        case (sel)
          asc_pkg::RS_MODE:   mode <= wr_word[15:0];
          asc_pkg::RS_CONFIG: config_reg <= wr_word[15:0];
          asc_pkg::RS_IO:     io_reg <= wr_word[7:0];
          default: begin
          end
        endcase
      end
      if (sgl_done) begin
        mode[asc_pkg::MODE_OP_HI:asc_pkg::MODE_OP_LO] <= asc_pkg::OP_PWRDN;  // [R11]
      end
    end
  end

  // ==========================================================================
  // conversion sequencing and ready
  assign sgl_start = wr_fire & (sel == asc_pkg::RS_MODE)
                   & (wr_word[asc_pkg::MODE_OP_HI:asc_pkg::MODE_OP_LO] == asc_pkg::OP_SINGLE);
  assign sgl_done  = CONV_STROBE & (op == asc_pkg::OP_SINGLE) & (osc_cnt == '0) & sgl_cnt;
  assign reading   = (state == asc_pkg::ST_READ) & (sel == asc_pkg::RS_DATA) & ~cread;
  assign accept    = CONV_STROBE & ~reading  // [R15]
                   & ((op == asc_pkg::OP_CONT) | sgl_done);  // [R12]

  always_ff @(posedge CORE_CLK) begin
    if (RST || soft_rst) begin
      osc_cnt  <= '0;
      sgl_cnt  <= 1'b0;
      upd_pend <= 1'b0;
      res_hold <= '0;
      data_reg <= '0;  // [R23]
      ready_n  <= 1'b1;
    end else begin
      upd_pend <= accept;
      if (sgl_start) begin
        osc_cnt <= OW'(OSC_START_CYCLES);  // [R12]
        sgl_cnt <= 1'b0;
      end else begin
        if (osc_cnt != '0) begin
          osc_cnt <= osc_cnt - OW'(1);
        end
        if (CONV_STROBE && op == asc_pkg::OP_SINGLE && osc_cnt == '0) begin
          sgl_cnt <= ~sgl_cnt;  // [R12]
        end
      end
      if (accept) begin
        res_hold <= CONV_RESULT;
        ready_n  <= 1'b1;  // [R4]
      end else if (upd_pend) begin
        data_reg <= res_hold;
        ready_n  <= 1'b0;  // [R3] [R14]
      end else if (rd_fire) begin
        ready_n <= 1'b1;  // [R3] [R13] [R17]
      end
    end
  end

  // ==========================================================================
  // filter choice
  always_comb begin
    next_filter = asc_pkg::FILT_SINC3_AVG;
    if (mode[asc_pkg::MODE_RATE_HI:asc_pkg::MODE_RATE_LO] <= asc_pkg::RATE_INT_MAX) begin
      next_filter = asc_pkg::FILT_INTEGRATE;  // [R21]
    end else if (mode[asc_pkg::MODE_RATE_HI:asc_pkg::MODE_RATE_LO] <= asc_pkg::RATE_SINC4_MAX) begin
      next_filter = asc_pkg::FILT_SINC4;  // [R21]
    end else if (mode[asc_pkg::MODE_RATE_HI:asc_pkg::MODE_RATE_LO] <= asc_pkg::RATE_MOD3_MAX) begin
      next_filter = asc_pkg::FILT_MOD_SINC3;  // [R21]
    end
  end

  // ==========================================================================
  // outputs
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      DOUT_O      <= 1'b1;
      DOUT_OE_N   <= 1'b1;
      MOD_RUN     <= 1'b0;
      FILTER_SEL  <= asc_pkg::FILT_SINC3_AVG;
      RATE_SEL    <= '0;
      CONFIG_WORD <= asc_pkg::CONFIG_RESET;
      IO_WORD     <= asc_pkg::IO_RESET;
    end else begin
      DOUT_OE_N   <= cs_nq;  // [R24] [R6]
      DOUT_O      <= (state == asc_pkg::ST_READ && out_live) ? out_sh[DATA_BITS-1]
                   : ready_n;  // [R3] [R22]
      MOD_RUN     <= (op == asc_pkg::OP_CONT) | (op == asc_pkg::OP_SINGLE);  // [R11]
      FILTER_SEL  <= next_filter;
      RATE_SEL    <= mode[asc_pkg::MODE_RATE_HI:asc_pkg::MODE_RATE_LO];
      CONFIG_WORD <= config_reg;
      IO_WORD     <= io_reg;
    end
  end

  // ==========================================================================
  // checks
  default clocking dcb @(posedge CORE_CLK); endclocking
  default disable iff (RST || soft_rst);

  chk_cs_float: assert property (cs_nq |=> DOUT_OE_N)  // [R24]
    else $error("output driven while deselected");
  chk_update_order: assert property (accept |=> (ready_n && upd_pend)  // [R4]
      ##1 (data_reg == $past(CONV_RESULT, 2)))
    else $error("data updated without ready high first");
  chk_read_clears: assert property (rd_fire && !upd_pend && !accept |=> ready_n)  // [R3]
    else $error("ready not raised after data read");
  chk_busy_drop: assert property (CONV_STROBE && reading |=> !upd_pend)  // [R15]
    else $error("word accepted during a data read");
  chk_cmd_write: assert property (rise_act && state == asc_pkg::ST_CMD && !cread  // [R2]
      && bit_cnt == CMD_LAST && !cmd_byte[asc_pkg::CMD_WEN_BIT]
      && !cmd_byte[asc_pkg::CMD_RW_BIT]
      |=> state == asc_pkg::ST_WRITE && sel == $past(cmd_rs))
    else $error("write command not decoded");
  chk_cread_enter: assert property (rise_act && state == asc_pkg::ST_CMD && !cread  // [R16]
      && bit_cnt == CMD_LAST && cmd_byte == asc_pkg::CREAD_ENTER |=> cread)
    else $error("continuous read not entered");
  chk_cread_reload: assert property (cread && upd_pend  // [R18]
      |=> state == asc_pkg::ST_READ && out_sh == $past(res_hold) && bit_cnt == '0)
    else $error("continuous read word not reloaded");
  chk_single_end: assert property (sgl_done |=> op == asc_pkg::OP_PWRDN ##1 !MOD_RUN)  // [R11]
    else $error("single conversion did not power down");
  chk_osc_wait: assert property (sgl_start |=> osc_cnt == OW'(OSC_START_CYCLES) && !sgl_cnt)  // [R12]
    else $error("oscillator start-up not timed");
  chk_ones_reset: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R9]
      soft_rst |=> state == asc_pkg::ST_CMD && mode == asc_pkg::MODE_RESET && !cread)
    else $error("serial reset incomplete");
  chk_dout_ready: assert property (!cs_nq && (state != asc_pkg::ST_READ || !out_live)  // [R14]
      |=> DOUT_O == $past(ready_n) && !DOUT_OE_N)
    else $error("ready not shown on output line");

endmodule

/* common/asc_pkg.sv */
package asc_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_START_US  = 1000;
  localparam int OSC_START_CYC = (OSC_START_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================================
  // command byte layout
  localparam int CMD_WEN_BIT   = 7;
  localparam int CMD_RW_BIT    = 6;
  localparam int CMD_RS_HI     = 5;
  localparam int CMD_RS_LO     = 3;
  localparam int CMD_CREAD_BIT = 2;
  localparam logic [7:0] CREAD_ENTER = 8'h5C;
  localparam logic [7:0] CREAD_EXIT  = 8'h58;

  // ==========================================================================
  // register_select_field codes
  localparam logic [2:0] RS_STATUS = 3'h0;
  localparam logic [2:0] RS_MODE   = 3'h1;
  localparam logic [2:0] RS_CONFIG = 3'h2;
  localparam logic [2:0] RS_DATA   = 3'h3;
  localparam logic [2:0] RS_ID     = 3'h4;
  localparam logic [2:0] RS_IO     = 3'h5;

  // ==========================================================================
  // register layouts and power-on values
  localparam int LEN_BYTE       = 8;
  localparam int LEN_WORD       = 16;
  localparam int STATUS_RDY_BIT = 7;
  localparam int MODE_OP_HI     = 15;
  localparam int MODE_OP_LO     = 13;
  localparam int MODE_RATE_HI   = 3;
  localparam int MODE_RATE_LO   = 0;
  localparam logic [15:0] MODE_RESET   = 16'h000A;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [7:0]  IO_RESET     = 8'h00;

  // operating_mode_field codes
  localparam logic [2:0] OP_CONT   = 3'h0;
  localparam logic [2:0] OP_SINGLE = 3'h1;
  localparam logic [2:0] OP_IDLE   = 3'h2;
  localparam logic [2:0] OP_PWRDN  = 3'h3;

  // ==========================================================================
  // serial reset by a run of ones
  localparam logic [5:0] ONES_RESET = 6'h20;
  localparam logic [5:0] ONES_LAST  = ONES_RESET - 6'h01;

  // ==========================================================================
  // update-rate code to filter choice
  localparam logic [3:0] RATE_INT_MAX   = 4'h1;
  localparam logic [3:0] RATE_SINC4_MAX = 4'h7;
  localparam logic [3:0] RATE_MOD3_MAX  = 4'hB;
  localparam logic [1:0] FILT_SINC3_AVG = 2'h0;
  localparam logic [1:0] FILT_MOD_SINC3 = 2'h1;
  localparam logic [1:0] FILT_SINC4     = 2'h2;
  localparam logic [1:0] FILT_INTEGRATE = 2'h3;

  typedef enum logic [1:0] {ST_CMD, ST_WRITE, ST_READ} asc_state_t;

endpackage

/* hdl/asc_sync.sv */
// three-stage synchroniser; the output follows once stages two and three agree
module asc_sync #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level in and out
  input  wire logic d,
  output logic      q
);

  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q  <= INIT;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end

endmodule

/* sim/asc_host.sv */
// ==========================================================================
// host serial port model
module asc_host (
  // lines driven by the host
  output logic      sclk,
  output logic      din,
  output logic      cs_n,
  // line driven by the device
  input  wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam time HALF = 40ns;

  initial begin
    sclk = 1'b1;
    din  = 1'b0;
    cs_n = 1'b1;
  end

  // one frame, msb first; input set while clock low, output taken late in the high phase
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    rx   = '0;
    cs_n = 1'b0;
    #HALF;
    for (int i = nbits - 1; i >= 0; i--) begin
      sclk = 1'b0;
      din  = tx[i];
      #HALF;
      sclk = 1'b1;
      #(HALF - 2ns);
      rx[i] = dout;
      #2ns;
    end
    din = 1'b0;
  endtask

  // free-running clocks with a fixed input level and select
  task automatic idle(input int n, input logic d, input logic cs);
    cs_n = cs;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      din  = d;
      #HALF;
      sclk = 1'b1;
      #HALF;
    end
    din = 1'b0;
  endtask
endmodule

/* sim/asc_top_tb.sv */
// ==========================================================================
// testbench
module asc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] ID_ARB = 8'h3C;  // arbitrary identification value

  typedef struct packed {
    logic [3:0] rate;
    logic [1:0] filt;
  } asc_row_t;

  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        strobe   = 1'b0;
  logic [23:0] result   = 24'h000000;
  logic        sclk;
  logic        din;
  logic        cs_n;
  logic        dout_o;
  logic        dout_oe_n;
  logic        mod_run;
  logic [1:0]  filter_sel;
  logic [3:0]  rate_sel;
  logic [15:0] config_word;
  logic [7:0]  io_word;
  logic [23:0] rx;
  logic [31:0] raw;
  int          bad_count = 0;
  int          tests_run = 0;

  asc_row_t rows [9] = '{
    '{4'h0, asc_pkg::FILT_INTEGRATE}, '{4'h1, asc_pkg::FILT_INTEGRATE},
    '{4'h2, asc_pkg::FILT_SINC4},     '{4'h7, asc_pkg::FILT_SINC4},
    '{4'h8, asc_pkg::FILT_MOD_SINC3}, '{4'hB, asc_pkg::FILT_MOD_SINC3},
    '{4'hC, asc_pkg::FILT_SINC3_AVG}, '{4'hF, asc_pkg::FILT_SINC3_AVG},
    '{4'hA, asc_pkg::FILT_MOD_SINC3}
  };

  always #5 core_clk = ~core_clk;

  asc_top #(
    .DATA_BITS        (24),
    .OSC_START_CYCLES (20),
    .ID_VALUE         (ID_ARB)
  ) dut (
    .CORE_CLK    (core_clk),
    .RST         (rst),
    .SCLK        (sclk),
    .DIN         (din),
    .CS_N        (cs_n),
    .DOUT_O      (dout_o),
    .DOUT_OE_N   (dout_oe_n),
    .CONV_STROBE (strobe),
    .CONV_RESULT (result),
    .MOD_RUN     (mod_run),
    .FILTER_SEL  (filter_sel),
    .RATE_SEL    (rate_sel),
    .CONFIG_WORD (config_word),
    .IO_WORD     (io_word)
  );

  asc_host host (
    .sclk (sclk),
    .din  (din),
    .cs_n (cs_n),
    .dout (dout_o)
  );

  task automatic summarize();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // command byte followed by n data bits; returns the data-phase bits
  task automatic acc(input logic [7:0] cmd, input logic [23:0] data, input int n,
                     output logic [23:0] got);
    logic [31:0] tx;
    logic [31:0] back;
    tx = ({24'h000000, cmd} << n) | {8'h00, data};
    host.xfer(tx, n + 8, back);
    got = back[23:0] & ((24'h000001 << n) - 24'h000001);
    repeat (10) @(negedge core_clk);
  endtask

  task automatic conv(input logic [23:0] value);
    @(negedge core_clk);
    strobe = 1'b1;
    result = value;
    @(negedge core_clk);
    strobe = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask

  initial begin
    #500us;
    bad_count++;
    summarize();
  end

  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    repeat (8) @(negedge core_clk);
    check(dout_oe_n, 1'b1);
    check(mod_run, 1'b1);
    check(rate_sel, 4'hA);
    // range ends and reset code: rate code against filter choice and read-back
    foreach (rows[i]) begin
      acc(8'h08, {20'h00000, rows[i].rate}, 16, rx);
      check(rate_sel, rows[i].rate);
      check(filter_sel, rows[i].filt);
      acc(8'h48, 24'h000000, 16, rx);
      check(rx, {20'h00000, rows[i].rate});
    end
    check(dout_oe_n, 1'b0);
    // ready line, status poll, read and reread
    conv(24'hA5C3F0);
    check(dout_o, 1'b0);
    acc(8'h40, 24'h000000, 8, rx);
    check(rx[7], 1'b0);
    acc(8'h58, 24'h000000, 24, rx);
    check(rx, 24'hA5C3F0);
    check(dout_o, 1'b1);
    acc(8'h58, 24'h000000, 24, rx);
    check(rx, 24'hA5C3F0);
    // a word that completes in the middle of a data read is dropped
    fork
      acc(8'h58, 24'h000000, 24, rx);
      begin
        repeat (120) @(negedge core_clk);
        conv(24'h0DD0DD);
      end
    join
    check(rx, 24'hA5C3F0);
    check(dout_o, 1'b1);
    acc(8'h18, 24'hFFFFFF, 24, rx);
    acc(8'h58, 24'h000000, 24, rx);
    check(rx, 24'hA5C3F0);
    acc(8'h28, 24'h000040, 8, rx);
    check(io_word, 8'h40);
    acc(8'h60, 24'h000000, 8, rx);
    check(rx, {16'h0000, ID_ARB});
    // single conversion: start-up, discarded period, then power-down
    acc(8'h08, 24'h00200A, 16, rx);
    check(mod_run, 1'b1);
    repeat (40) @(negedge core_clk);
    conv(24'h111111);
    check(dout_o, 1'b1);
    conv(24'h5A0F3C);
    check(dout_o, 1'b0);
    check(mod_run, 1'b0);
    acc(8'h58, 24'h000000, 24, rx);
    check(rx, 24'h5A0F3C);
    conv(24'h777777);
    check(dout_o, 1'b1);
    // continuous read: auto output, replacement of unread word, exit
    acc(8'h08, 24'h00000A, 16, rx);
    host.xfer(32'h0000005C, 8, raw);
    conv(24'hC0FFEE);
    host.xfer(32'h00000000, 24, raw);
    check(raw[23:0], 24'hC0FFEE);
    repeat (10) @(negedge core_clk);
    check(dout_o, 1'b1);
    conv(24'h123456);
    conv(24'h654321);
    host.xfer(32'h00000000, 24, raw);
    check(raw[23:0], 24'h654321);
    conv(24'h0BCDEF);
    host.xfer(32'h00000058, 8, raw);
    repeat (10) @(negedge core_clk);
    acc(8'h58, 24'h000000, 24, rx);
    check(rx, 24'h0BCDEF);
    // deselected activity ignored, then a run of ones resets everything
    acc(8'h10, 24'h001234, 16, rx);
    check(config_word, 16'h1234);
    host.idle(40, 1'b1, 1'b1);
    repeat (10) @(negedge core_clk);
    check(dout_oe_n, 1'b1);
    check(config_word, 16'h1234);
    host.xfer(32'hFFFFFFFF, 32, raw);
    repeat (10) @(negedge core_clk);
    check(config_word, 16'h0000);
    check(io_word, 8'h00);
    check(rate_sel, 4'hA);
    // settle wait after an interface reset is shortened to keep the run short
    acc(8'h60, 24'h000000, 8, rx);
    check(rx, {16'h0000, ID_ARB});
    summarize();
  end
endmodule
